// *** hdl/css_clock_startup.sv ***
// clock source decode, start-up sequencing and avalon register slave
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module css_clock_startup
  import css_pkg::*;
#(
  parameter int unsigned LONG_DLY_CYC = 65536,
  parameter int unsigned CK_16K_CYC   = 16384,
  parameter int unsigned CK_32K_CYC   = 32768
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  // avalon-mm slave
  input  wire logic [3:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  // fuse pins, raw polarity
  input  wire logic [3:0]  clock_source_select_fuses_i,
  input  wire logic [1:0]  startup_time_select_i,
  input  wire logic        amplifier_option_fuse_i,
  // oscillators sampled as data, wake pin
  input  wire logic        watchdog_oscillator_i,
  input  wire logic        selected_clock_i,
  input  wire logic        wake_i,
  // clock generator enables and status
  output logic             exec_enable_o,
  output logic             cpu_clk_en_o,
  output logic             io_clk_en_o,
  output logic             converter_clk_en_o,
  output logic             async_timer_clk_en_o,
  output logic [2:0]       source_kind_o,
  output logic [2:0]       freq_range_o,
  output logic             full_swing_o
);

  localparam logic [16:0] LONG_DLY = 17'(LONG_DLY_CYC);
  localparam logic [16:0] CK_16K   = 17'(CK_16K_CYC);
  localparam logic [16:0] CK_32K   = 17'(CK_32K_CYC);

  // pin synchronisers
  logic [6:0] fuse_s1;
  logic [6:0] fuse_s2;
  logic       wake_s1;
  logic       wake_s2;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fuse_s1 <= 7'h00;
      fuse_s2 <= 7'h00;
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
    end else if (ce_i) begin
      fuse_s1 <= {amplifier_option_fuse_i, startup_time_select_i,
                  clock_source_select_fuses_i};
      fuse_s2 <= fuse_s1;
      wake_s1 <= wake_i;
      wake_s2 <= wake_s1;
    end
  end

  // state
  css_state_t  state;
  css_state_t  next_state;
  logic [1:0]  settle;
  logic [1:0]  next_settle;
  logic [3:0]  fuse_src;
  logic [3:0]  next_fuse_src;
  logic [1:0]  fuse_sut;
  logic [1:0]  next_fuse_sut;
  logic        fuse_amp;
  logic        next_fuse_amp;
  logic [2:0]  ctrl_mode;
  logic [2:0]  next_ctrl_mode;
  logic        ctrl_asy;
  logic        next_ctrl_asy;
  logic [2:0]  sleep_mode;
  logic [2:0]  next_sleep_mode;
  logic        wdt_start;
  logic        ck_start;
  logic        wdt_done;
  logic        ck_done;

  // decode of captured fuses
  logic [2:0]  src_kind;
  logic [2:0]  freq_rng;
  logic [16:0] start_ck;
  logic [16:0] rst_dly;
  logic [2:0]  xtal_opt;

  assign xtal_opt = {fuse_src[0], fuse_sut};

  // fuse zero means programmed; codes compared in that sense
  always_comb begin
    src_kind = CSS_SRC_XTAL;
    freq_rng = CSS_FR_NONE;
    start_ck = CSS_CK_6;
    rst_dly  = LONG_DLY;
    if (fuse_src >= 4'ha) begin
      src_kind = CSS_SRC_XTAL;
      if (!fuse_amp) begin
        freq_rng = CSS_FR_WIDE;
      end else begin
        unique case (fuse_src[3:1])
          3'h5:    freq_rng = CSS_FR_LOW;
          3'h6:    freq_rng = CSS_FR_MID;
          default: freq_rng = CSS_FR_HIGH;
        endcase
      end
      unique case (xtal_opt)
        3'h0: begin
          start_ck = CSS_CK_258;
          rst_dly  = CSS_WDT_SHORT;
        end
        3'h1: begin
          start_ck = CSS_CK_258;
          rst_dly  = LONG_DLY;
        end
        3'h2: begin
          start_ck = CSS_CK_1K;
          rst_dly  = CSS_CNT_ZERO;
        end
        3'h3: begin
          start_ck = CSS_CK_1K;
          rst_dly  = CSS_WDT_SHORT;
        end
        3'h4: begin
          start_ck = CSS_CK_1K;
          rst_dly  = LONG_DLY;
        end
        3'h5: begin
          start_ck = CK_16K;
          rst_dly  = CSS_CNT_ZERO;
        end
        3'h6: begin
          start_ck = CK_16K;
          rst_dly  = CSS_WDT_SHORT;
        end
        3'h7: begin
          start_ck = CK_16K;
          rst_dly  = LONG_DLY;
        end
      endcase
    end else if (fuse_src == 4'h9) begin
      src_kind = CSS_SRC_LFXTAL;
      start_ck = (fuse_sut[1]) ? CK_32K : CSS_CK_1K;
      rst_dly  = (fuse_sut == 2'h0) ? CSS_WDT_SHORT : LONG_DLY;
    end else if (fuse_src >= 4'h5) begin
      src_kind = CSS_SRC_EXTRC;
      start_ck = (fuse_sut == 2'h3) ? CSS_CK_6 : CSS_CK_18;
      unique case (fuse_sut)
        2'h0:    rst_dly = CSS_CNT_ZERO;
        2'h2:    rst_dly = LONG_DLY;
        default: rst_dly = CSS_WDT_SHORT;
      endcase
    end else begin
      src_kind = (fuse_src == 4'h0) ? CSS_SRC_EXTCLK : CSS_SRC_INTRC;
      start_ck = CSS_CK_6;
      // reserved code 11 is given the safe long delay
      unique case (fuse_sut)
        2'h0:    rst_dly = CSS_CNT_ZERO;
        2'h1:    rst_dly = CSS_WDT_SHORT;
        default: rst_dly = LONG_DLY;
      endcase
    end
  end

  // bus decode
  logic        bus_req;
  logic        bus_take;
  logic        wr_ctrl;
  logic        go_req;
  logic        next_wait;
  logic [31:0] next_rdata;
  logic        asy_grant;
  logic        asy_refused;

  assign bus_req  = read_i | write_i;
  assign bus_take = bus_req & ~waitrequest_o;
  assign wr_ctrl  = bus_take & write_i & byteenable_i[0]
                    & (address_i == CSS_REG_CTRL);
  assign go_req   = wr_ctrl & writedata_i[CSS_CTRL_GO_BIT];

  // async timer shares the oscillator pins with the crystal sources
  assign asy_grant   = ctrl_asy & (src_kind == CSS_SRC_INTRC);
  assign asy_refused = ctrl_asy & (src_kind != CSS_SRC_INTRC);

  // one wait state: answer on the edge after the request is seen
  always_comb begin
    next_wait  = 1'b1;
    next_rdata = readdata_o;
    if (bus_req && waitrequest_o) begin
      next_wait  = 1'b0;
      next_rdata = 32'h0000_0000;
      unique case (address_i)
        CSS_REG_CTRL:
          next_rdata[4:0] = {ctrl_asy, 1'b0, ctrl_mode};
        CSS_REG_STATUS:
          next_rdata[6:0] = {asy_refused, asy_grant, exec_enable_o,
                             1'b0, 3'(state)};
        CSS_REG_CONFIG:
          next_rdata[12:0] = {freq_rng, src_kind, fuse_amp, fuse_sut,
                              fuse_src};
        CSS_REG_STARTUP:
          next_rdata[16:0] = start_ck;
        default:
          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // sequencer
  always_comb begin
    next_state      = state;
    next_settle     = settle;
    next_fuse_src   = fuse_src;
    next_fuse_sut   = fuse_sut;
    next_fuse_amp   = fuse_amp;
    next_ctrl_mode  = ctrl_mode;
    next_ctrl_asy   = ctrl_asy;
    next_sleep_mode = sleep_mode;
    wdt_start       = 1'b0;
    ck_start        = 1'b0;
    if (wr_ctrl) begin
      next_ctrl_mode = writedata_i[CSS_CTRL_MODE_LSB +: 3];
      next_ctrl_asy  = writedata_i[CSS_CTRL_ASY_BIT];
    end
    unique case (state)
      ST_CAPTURE: begin
        // fuses are sampled only once the synchronisers are full
        next_settle = settle + 2'h1;
        if (settle == CSS_FUSE_SETTLE) begin
          next_fuse_src = fuse_s2[3:0];
          next_fuse_sut = fuse_s2[5:4];
          next_fuse_amp = fuse_s2[6];
          next_state    = ST_DECODE;
        end
      end
      ST_DECODE: begin
        wdt_start  = 1'b1;
        next_state = ST_RST_DELAY;
      end
      ST_RST_DELAY: begin
        if (wdt_done) begin
          ck_start   = 1'b1;
          next_state = ST_START_CK;
        end
      end
      ST_START_CK: begin
        if (ck_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (go_req) begin
          next_sleep_mode = writedata_i[CSS_CTRL_MODE_LSB +: 3];
          if (next_sleep_mode >= CSS_SLP_IDLE
              && next_sleep_mode <= CSS_SLP_PSAVE) begin
            next_state = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        if (wake_s2) begin
          if (sleep_mode == CSS_SLP_PDOWN
              || sleep_mode == CSS_SLP_PSAVE) begin
            ck_start   = 1'b1;
            next_state = ST_WAKE_CK;
          end else begin
            next_state = ST_RUN;
          end
        end
      end
      ST_WAKE_CK: begin
        if (ck_done) begin
          next_state = ST_RUN;
        end
      end
    endcase
  end

  // clock generator enables
  logic next_exec;
  logic next_cpu;
  logic next_io;
  logic next_conv;
  logic next_asy;
  logic sleeping;

  assign sleeping = (next_state == ST_SLEEP);

  always_comb begin
    next_exec = (next_state == ST_RUN);
    next_cpu  = (next_state == ST_RUN);
    next_io   = next_cpu | (sleeping && next_sleep_mode == CSS_SLP_IDLE);
    next_conv = next_io
                | (sleeping && next_sleep_mode == CSS_SLP_NOISE);
    next_asy  = asy_grant & (next_state != ST_CAPTURE)
                & ~(sleeping && next_sleep_mode == CSS_SLP_PDOWN);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state                <= ST_CAPTURE;
      settle               <= 2'h0;
      fuse_src             <= CSS_FUSE_SRC_RST;
      fuse_sut             <= CSS_FUSE_SUT_RST;
      fuse_amp             <= CSS_FUSE_AMP_RST;
      ctrl_mode            <= CSS_CTRL_MODE_RST;
      ctrl_asy             <= CSS_CTRL_ASY_RST;
      sleep_mode           <= CSS_CTRL_MODE_RST;
      waitrequest_o        <= 1'b1;
      readdata_o           <= 32'h0000_0000;
      exec_enable_o        <= 1'b0;
      cpu_clk_en_o         <= 1'b0;
      io_clk_en_o          <= 1'b0;
      converter_clk_en_o   <= 1'b0;
      async_timer_clk_en_o <= 1'b0;
      source_kind_o        <= CSS_SRC_INTRC;
      freq_range_o         <= CSS_FR_NONE;
      full_swing_o         <= 1'b0;
    end else if (ce_i) begin
      state                <= next_state;
      settle               <= next_settle;
      fuse_src             <= next_fuse_src;
      fuse_sut             <= next_fuse_sut;
      fuse_amp             <= next_fuse_amp;
      ctrl_mode            <= next_ctrl_mode;
      ctrl_asy             <= next_ctrl_asy;
      sleep_mode           <= next_sleep_mode;
      waitrequest_o        <= next_wait;
      readdata_o           <= next_rdata;
      exec_enable_o        <= next_exec;
      cpu_clk_en_o         <= next_cpu;
      io_clk_en_o          <= next_io;
      converter_clk_en_o   <= next_conv;
      async_timer_clk_en_o <= next_asy;
      source_kind_o        <= src_kind;
      freq_range_o         <= freq_rng;
      full_swing_o         <= (src_kind == CSS_SRC_XTAL) & ~fuse_amp;
    end
  end

  // supply-settling delay timed on the watchdog oscillator
  css_tick_counter u_wdt_delay (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .ce_i     (ce_i),
    .start_i  (wdt_start),
    .target_i (rst_dly),
    .tick_i   (watchdog_oscillator_i),
    .done_o   (wdt_done)
  );

  // start-up count timed on the selected source itself
  css_tick_counter u_ck_delay (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .ce_i     (ce_i),
    .start_i  (ck_start),
    .target_i (start_ck),
    .tick_i   (selected_clock_i),
    .done_o   (ck_done)
  );

endmodule : css_clock_startup

// *** hdl/css_pkg.sv ***
// constants and types for the clock source and start-up selector
// Behaviour
// - four fuse bits pick the clock source
// - fuse reads one unprogrammed, zero programmed
// - selected clock feeds the clock generator enables
// - wake from deep sleep counts start-up cycles
// - reset adds supply delay on watchdog oscillator
// - reset delay is 0, 4096 or 65536 cycles
// - unprogrammed default is 0001 with start-up 10
// - async timer domain keeps running during sleep except power-down
// - async timer only with internal RC clock
// - converter clock runs during noise reduction
// - upper select bits give crystal frequency range
// - low select bit and start-up field pick delays
// - low bit 0: 258/258/1K/1K start-up options
// - low bit 1: 1K/16K/16K/16K start-up options
package css_pkg;

  // register map, byte addresses on the bus
  localparam logic [3:0]  CSS_REG_CTRL     = 4'h0;
  localparam logic [3:0]  CSS_REG_STATUS   = 4'h4;
  localparam logic [3:0]  CSS_REG_CONFIG   = 4'h8;
  localparam logic [3:0]  CSS_REG_STARTUP  = 4'hc;

  // control register fields
  localparam int          CSS_CTRL_MODE_LSB = 0;
  localparam int          CSS_CTRL_GO_BIT   = 3;
  localparam int          CSS_CTRL_ASY_BIT  = 4;
  localparam logic [2:0]  CSS_CTRL_MODE_RST = 3'h0;
  localparam logic        CSS_CTRL_ASY_RST  = 1'b0;

  // sleep modes written to the control register
  localparam logic [2:0]  CSS_SLP_IDLE  = 3'h1;
  localparam logic [2:0]  CSS_SLP_NOISE = 3'h2;
  localparam logic [2:0]  CSS_SLP_PDOWN = 3'h3;
  localparam logic [2:0]  CSS_SLP_PSAVE = 3'h4;

  // fuse values before capture: the factory default
  localparam logic [3:0]  CSS_FUSE_SRC_RST = 4'h1;
  localparam logic [1:0]  CSS_FUSE_SUT_RST = 2'h2;
  localparam logic        CSS_FUSE_AMP_RST = 1'b1;

  // decoded source kinds
  localparam logic [2:0]  CSS_SRC_XTAL   = 3'h0;
  localparam logic [2:0]  CSS_SRC_LFXTAL = 3'h1;
  localparam logic [2:0]  CSS_SRC_EXTRC  = 3'h2;
  localparam logic [2:0]  CSS_SRC_INTRC  = 3'h3;
  localparam logic [2:0]  CSS_SRC_EXTCLK = 3'h4;

  // crystal frequency range codes
  localparam logic [2:0]  CSS_FR_NONE = 3'h0;
  localparam logic [2:0]  CSS_FR_LOW  = 3'h1;
  localparam logic [2:0]  CSS_FR_MID  = 3'h2;
  localparam logic [2:0]  CSS_FR_HIGH = 3'h3;
  localparam logic [2:0]  CSS_FR_WIDE = 3'h4;

  // cycle counts
  localparam int          CSS_CNT_W       = 17;
  localparam logic [16:0] CSS_CK_6        = 17'h00006;
  localparam logic [16:0] CSS_CK_18       = 17'h00012;
  localparam logic [16:0] CSS_CK_258      = 17'h00102;
  localparam logic [16:0] CSS_CK_1K       = 17'h00400;
  localparam logic [16:0] CSS_WDT_SHORT   = 17'h01000;
  localparam logic [16:0] CSS_CNT_ZERO    = 17'h00000;
  localparam logic [1:0]  CSS_FUSE_SETTLE = 2'h3;

  typedef enum logic [2:0] {
    ST_CAPTURE,
    ST_DECODE,
    ST_RST_DELAY,
    ST_START_CK,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE_CK
  } css_state_t;

endpackage : css_pkg

// *** hdl/css_tick_counter.sv ***
// counts rising edges of an asynchronous clock up to a target
`timescale 1ns/1ps
module css_tick_counter
  import css_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 ce_i,
  // control
  input  wire logic                 start_i,
  input  wire logic [CSS_CNT_W-1:0] target_i,
  // foreign clock sampled as data
  input  wire logic                 tick_i,
  // result
  output logic                      done_o
);

  logic                 sync_a;
  logic                 sync_b;
  logic                 sync_c;
  logic [CSS_CNT_W-1:0] count;
  logic [CSS_CNT_W-1:0] target;
  logic [CSS_CNT_W-1:0] next_count;
  logic [CSS_CNT_W-1:0] next_target;
  logic                 next_done;
  logic                 edge_seen;

  // two flops before any logic; edge taken from the second and third
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else if (ce_i) begin
      sync_a <= tick_i;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign edge_seen = sync_b & ~sync_c;

  // the foreign clock must be below half of clk_i or edges are missed
  always_comb begin
    next_count  = count;
    next_target = target;
    next_done   = done_o;
    if (start_i) begin
      next_count  = CSS_CNT_ZERO;
      next_target = target_i;
      next_done   = (target_i == CSS_CNT_ZERO);
    end else if (!done_o && edge_seen) begin
      next_count = count + 17'h00001;
      next_done  = (next_count == target);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count  <= CSS_CNT_ZERO;
      target <= CSS_CNT_ZERO;
      done_o <= 1'b0;
    end else if (ce_i) begin
      count  <= next_count;
      target <= next_target;
      done_o <= next_done;
    end
  end

endmodule : css_tick_counter

// *** tb/css_osc_model.sv ***
// free running watchdog and selected-source oscillator model
`timescale 1ns/1ps
module css_osc_model #(
  parameter int HALF_WDT = 2,
  parameter int HALF_SEL = 2
) (
  // system clock
  input  wire logic clk_i,
  // oscillator outputs
  output logic      wdt_o,
  output logic      sel_o
);
  int wn = 0;
  int sn = 1;
  initial wdt_o = 1'b0;
  initial sel_o = 1'b0;
  // watchdog oscillator runs apart from the selected source
  // both stay below clk/2 so the edge sync can follow them
  // behaves as a ceramic resonator, so short and low range codes are fair
  always @(posedge clk_i) begin
    wn = (wn + 1) % HALF_WDT;
    sn = (sn + 1) % HALF_SEL;
    if (wn == 0) wdt_o <= ~wdt_o;
    if (sn == 0) sel_o <= ~sel_o;
  end
endmodule : css_osc_model

// *** tb/css_clock_startup_checker.sv ***
// assertion checker for the clock source and start-up selector
`timescale 1ns/1ps
module css_clock_startup_checker
  import css_pkg::*;
(
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  // bus
  input wire logic       read_i,
  input wire logic       write_i,
  input wire logic       waitrequest_o,
  // fuse pins
  input wire logic [3:0] clock_source_select_fuses_i,
  input wire logic       amplifier_option_fuse_i,
  // enables and decode
  input wire logic       exec_enable_o,
  input wire logic       cpu_clk_en_o,
  input wire logic       io_clk_en_o,
  input wire logic       converter_clk_en_o,
  input wire logic       async_timer_clk_en_o,
  input wire logic [2:0] source_kind_o,
  input wire logic [2:0] freq_range_o,
  input wire logic       full_swing_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [3:0] f;
  logic [2:0] kind;
  assign f = clock_source_select_fuses_i;
  // pins only move in reset, so while running they equal the capture
  assign kind = (f >= 4'ha) ? CSS_SRC_XTAL : (f == 4'h9) ? CSS_SRC_LFXTAL :
                (f >= 4'h5) ? CSS_SRC_EXTRC :
                (f != 4'h0) ? CSS_SRC_INTRC : CSS_SRC_EXTCLK;
  AST_KIND: assert property (
    exec_enable_o |-> source_kind_o == kind) else $error("kind wrong");
  AST_FR: assert property (
    exec_enable_o && kind == CSS_SRC_XTAL |-> freq_range_o ==
    (amplifier_option_fuse_i ? f[3:1] - 3'h4 : CSS_FR_WIDE))
    else $error("range wrong");
  AST_NOFR: assert property (
    source_kind_o != CSS_SRC_XTAL |-> freq_range_o == CSS_FR_NONE)
    else $error("range set for non crystal");
  AST_SWING: assert property (
    full_swing_o == (source_kind_o == CSS_SRC_XTAL &&
    freq_range_o == CSS_FR_WIDE)) else $error("swing wrong");
  AST_CPU: assert property (
    cpu_clk_en_o == exec_enable_o) else $error("cpu enable wrong");
  AST_RUN: assert property (
    cpu_clk_en_o |-> io_clk_en_o && converter_clk_en_o)
    else $error("run enables wrong");
  AST_CONV: assert property (
    io_clk_en_o |-> converter_clk_en_o) else $error("converter off");
  AST_ASY: assert property (
    async_timer_clk_en_o |-> source_kind_o == CSS_SRC_INTRC)
    else $error("async timer on wrong source");
  AST_ANS: assert property (
    (read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("no answer");
  AST_ONE: assert property (
    !waitrequest_o |=> waitrequest_o) else $error("answer too long");
  cover property ($rose(exec_enable_o));
  cover property (async_timer_clk_en_o && !cpu_clk_en_o);
  cover property (converter_clk_en_o && !io_clk_en_o);
  cover property (io_clk_en_o && !cpu_clk_en_o);
endmodule : css_clock_startup_checker

bind css_clock_startup css_clock_startup_checker u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .read_i(read_i), .write_i(write_i),
  .waitrequest_o(waitrequest_o),
  .clock_source_select_fuses_i(clock_source_select_fuses_i),
  .amplifier_option_fuse_i(amplifier_option_fuse_i),
  .exec_enable_o(exec_enable_o), .cpu_clk_en_o(cpu_clk_en_o),
  .io_clk_en_o(io_clk_en_o), .converter_clk_en_o(converter_clk_en_o),
  .async_timer_clk_en_o(async_timer_clk_en_o),
  .source_kind_o(source_kind_o), .freq_range_o(freq_range_o),
  .full_swing_o(full_swing_o));

// *** tb/testbench.sv ***
// self-checking bench for the clock source and start-up selector
`timescale 1ns/1ps
module testbench
  import css_pkg::*;
;
  localparam int L = 40, S = 4096, K1 = 1024, K16 = 20, K32 = 30;
  localparam int K6 = 6, K18 = 18, K258 = 258, P = 4;
  typedef struct packed {
    logic [3:0] src; logic [1:0] startup_time_select; logic amp; logic [2:0] kind;
    logic [2:0] fr; logic sw; int wdt; int ck; logic full;
  } css_row_t;
  css_row_t rows [20] = '{
    '{4'h1, 2'h2, 1'b1, 3'h3, 3'h0, 1'b0, L, K6, 1'b1},
    '{4'h0, 2'h0, 1'b0, 3'h4, 3'h0, 1'b0, 0, K6, 1'b1},
    '{4'h5, 2'h0, 1'b1, 3'h2, 3'h0, 1'b0, 0, K18, 1'b1},
    '{4'h8, 2'h3, 1'b1, 3'h2, 3'h0, 1'b0, S, K6, 1'b0},
    '{4'h9, 2'h1, 1'b1, 3'h1, 3'h0, 1'b0, L, K1, 1'b0},
    '{4'h9, 2'h2, 1'b1, 3'h1, 3'h0, 1'b0, L, K32, 1'b1},
    '{4'ha, 2'h0, 1'b1, 3'h0, 3'h1, 1'b0, S, K258, 1'b0},
    '{4'ha, 2'h1, 1'b1, 3'h0, 3'h1, 1'b0, L, K258, 1'b1},
    '{4'hc, 2'h2, 1'b1, 3'h0, 3'h2, 1'b0, 0, K1, 1'b0},
    '{4'hc, 2'h3, 1'b1, 3'h0, 3'h2, 1'b0, S, K1, 1'b0},
    '{4'hf, 2'h0, 1'b1, 3'h0, 3'h3, 1'b0, L, K1, 1'b0},
    '{4'hf, 2'h1, 1'b0, 3'h0, 3'h4, 1'b1, 0, K16, 1'b1},
    '{4'hf, 2'h2, 1'b1, 3'h0, 3'h3, 1'b0, S, K16, 1'b0},
    '{4'hf, 2'h3, 1'b0, 3'h0, 3'h4, 1'b1, L, K16, 1'b1},
    '{4'h4, 2'h1, 1'b1, 3'h3, 3'h0, 1'b0, S, K6, 1'b1},
    '{4'h9, 2'h0, 1'b1, 3'h1, 3'h0, 1'b0, S, K1, 1'b0},
    '{4'h6, 2'h1, 1'b1, 3'h2, 3'h0, 1'b0, S, K18, 1'b0},
    '{4'h7, 2'h2, 1'b1, 3'h2, 3'h0, 1'b0, L, K18, 1'b1},
    '{4'h2, 2'h0, 1'b1, 3'h3, 3'h0, 1'b0, 0, K6, 1'b1},
    '{4'h3, 2'h3, 1'b1, 3'h3, 3'h0, 1'b0, L, K6, 1'b1}};
  logic clk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1;
  logic read_i = 1'b0, write_i = 1'b0, wake_i = 1'b0, amp = 1'b1;
  logic [3:0] address_i = 4'h0, byteenable_i = 4'hf, src = 4'h1;
  logic [1:0] startup_time_select = 2'h2;
  logic [31:0] writedata_i = 32'h0, readdata_o, q;
  logic waitrequest_o, exec_enable_o, cpu_clk_en_o, io_clk_en_o, wdt, sel;
  logic converter_clk_en_o, async_timer_clk_en_o, full_swing_o;
  logic [2:0] source_kind_o, freq_range_o;
  int error_cnt = 0, cmp_count = 0, cyc = 0, n = 0;

  css_clock_startup #(.LONG_DLY_CYC(L), .CK_16K_CYC(K16),
    .CK_32K_CYC(K32)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .clock_source_select_fuses_i(src),
    .startup_time_select_i(startup_time_select), .amplifier_option_fuse_i(amp),
    .watchdog_oscillator_i(wdt), .selected_clock_i(sel), .wake_i(wake_i),
    .exec_enable_o(exec_enable_o), .cpu_clk_en_o(cpu_clk_en_o),
    .io_clk_en_o(io_clk_en_o), .converter_clk_en_o(converter_clk_en_o),
    .async_timer_clk_en_o(async_timer_clk_en_o),
    .source_kind_o(source_kind_o), .freq_range_o(freq_range_o),
    .full_swing_o(full_swing_o));
  css_osc_model #(.HALF_WDT(2), .HALF_SEL(2)) u_osc (
    .clk_i(clk_i), .wdt_o(wdt), .sel_o(sel));

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic check(string s, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask : check

  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
    @(posedge clk_i);
    read_i <= !wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= d;
    do begin
      @(posedge clk_i);
    end while (waitrequest_o !== 1'b0);
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask : bus

  // waiting only on exec keeps the bench blind to internal phase
  task automatic run_to_exec(int lim);
    n = 0;
    while (exec_enable_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask : run_to_exec

  task automatic boot(css_row_t r);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    src <= r.src;
    startup_time_select <= r.startup_time_select;
    amp <= r.amp;
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    if (r.full) run_to_exec(20000);
    else repeat (100) @(posedge clk_i);
  endtask : boot

  task automatic nap(logic [31:0] d, logic [3:0] en, int lo, int hi);
    bus(1'b1, CSS_REG_CTRL, d);
    repeat (3) @(posedge clk_i);
    check("sleep_en", 32'({cpu_clk_en_o, io_clk_en_o, converter_clk_en_o,
          async_timer_clk_en_o}), 32'(en));
    wake_i <= 1'b1;
    run_to_exec(2000);
    wake_i <= 1'b0;
    check("wake_time", 32'(n >= lo && n <= hi), 32'h1);
  endtask : nap

  initial begin
    foreach (rows[i]) begin
      boot(rows[i]);
      if (rows[i].full) check("boot_time", 32'(n >= (rows[i].wdt +
        rows[i].ck) * P - 8 && n <= (rows[i].wdt + rows[i].ck) * P + 30),
        32'h1);
      else check("exec_held", 32'(exec_enable_o), 32'h0);
      bus(1'b0, CSS_REG_CONFIG, 32'h0);
      check("config", q, 32'({rows[i].fr, rows[i].kind, rows[i].amp,
            rows[i].startup_time_select, rows[i].src}));
      bus(1'b0, CSS_REG_STARTUP, 32'h0);
      check("startup", q, 32'(rows[i].ck));
      check("kind", 32'(source_kind_o), 32'(rows[i].kind));
      check("swing", 32'(full_swing_o), 32'(rows[i].sw));
    end
    // reset values, then the default fuses seen before capture
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    src <= 4'hf;
    startup_time_select <= 2'h1;
    amp <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("rst_out", 32'({waitrequest_o, exec_enable_o, cpu_clk_en_o,
          io_clk_en_o, converter_clk_en_o, async_timer_clk_en_o,
          source_kind_o, freq_range_o, full_swing_o}),
          32'({1'b1, 5'h00, CSS_SRC_INTRC, CSS_FR_NONE, 1'b0}));
    rst_b_i <= 1'b1;
    bus(1'b0, CSS_REG_CONFIG, 32'h0);
    check("fuse_dflt", q, 32'({CSS_FR_NONE, CSS_SRC_INTRC, CSS_FUSE_AMP_RST,
          CSS_FUSE_SUT_RST, CSS_FUSE_SRC_RST}));
    // crystal source: sleep modes and refused async timer
    boot(rows[13]);
    bus(1'b0, CSS_REG_CTRL, 32'h0);
    check("ctrl_rst", q, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    check("unmapped", q, 32'h0);
    byteenable_i <= 4'h0;
    bus(1'b1, CSS_REG_CTRL, 32'h10);
    byteenable_i <= 4'hf;
    bus(1'b0, CSS_REG_CTRL, 32'h0);
    check("ctrl_masked", q, 32'h0);
    bus(1'b1, CSS_REG_CTRL, 32'h10);
    bus(1'b0, CSS_REG_STATUS, 32'h0);
    check("asy_refused", q & 32'h60, 32'h40);
    nap(32'h19, 4'h6, 0, 8);
    nap(32'h1a, 4'h2, 0, 8);
    nap(32'h1b, 4'h0, K16 * P - 8, K16 * P + 30);
    // internal RC: async timer granted and kept in power-save
    boot(rows[0]);
    bus(1'b1, CSS_REG_CTRL, 32'h10);
    bus(1'b0, CSS_REG_STATUS, 32'h0);
    check("asy_granted", q & 32'h60, 32'h20);
    nap(32'h1c, 4'h1, K6 * P - 8, K6 * P + 30);
    nap(32'h1b, 4'h0, K6 * P - 8, K6 * P + 30);
    check("asy_back", 32'(async_timer_clk_en_o), 32'h1);
    wrap_up();
  end
endmodule : testbench
